// ### rtl/adsq_top.sv
// Converter sequencer control: APB registers, start/busy sequencing, pin overrides
// Function
// - Eight pin select bits route pins to analog channels; reset to all ones.
// - Start bit rising then falling launches one conversion.
// - Start held high resets converter and clears busy; no conversion meanwhile.
// - Busy flag sets once a conversion is launched.
// - Busy flag clears when conversion completes, result then valid.
// - Completion sets interrupt request flag; enabled request drives interrupt line.
// - Converter clock comes from system clock, divided by selected ratio.
// - Reference select decodes supply, external x1..x4, bandgap x2..x4.
// - Non-supply references pass an amplifier with gain 1 to 4.
// - External and bandgap together: bandgap alone is used.
// - Reference in/out pin function bits only drive their own outputs; pin overrides ignore them.
// - Analog channel selection overrides port direction, disables pin functions.
// - Pull-ups disconnect on pins configured as analog inputs.
// - Conversion takes 4 sample and 12 convert clocks, 16 total.
// - Divider select is a power of two, 000 undivided to 111 /128.
// - Justify bit places 12-bit result left or right in two bytes.
// - Clearing power enable powers down and zeroes both result bytes.
`timescale 1ns/1ps
module adsq_top
  import adsq_pkg::*;
#(
  parameter int RES_W = 12
)(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RES_W-1:0] conv_data,
  input wire logic [7:0] port_direction_in,
  input wire logic [7:0] pull_high_in,
  input wire logic interrupt_enable,
  output logic [7:0] analog_pin_enable_bits,
  output logic [7:0] port_direction_out,
  output logic [7:0] pull_high_out,
  output logic converter_power_enable,
  output logic converter_reset,
  output logic converter_sampling,
  output logic [2:0] channel_select,
  output logic [2:0] input_signal_select,
  output adsq_refcfg_t reference_cfg,
  output logic reference_amp_enable,
  output logic reference_in_pin_enable,
  output logic reference_out_pin,
  output logic conv_irq_flag,
  output logic conv_irq
);
  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] pinsel;
    logic [7:0] res_h;
    logic [7:0] res_l;
    logic busy;
    logic irq_flag;
    logic start_d1;
    adsq_state_t state;
    logic [4:0] clk_cnt;
    logic [7:0] pin_en;
    logic [7:0] dir;
    logic [7:0] pull;
    logic conv_rst;
    logic sampling;
    logic irq;
    adsq_refcfg_t ref_cfg;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } adsq_st_t;

  adsq_st_t s_q, s_d;
  logic conv_tick;
  adsq_refcfg_t ref_dec;
  logic start_now;
  logic start_rise;
  logic conv_run;
  logic [4:0] cnt_nx;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_word;
  logic [7:0] res_h_nx;
  logic [7:0] res_l_nx;
  logic [7:0] pin_nx;
  logic [7:0] dir_nx;
  logic [7:0] pull_nx;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  adsq_clkdiv u_clkdiv (
    .clock(clock),
    .reset_n(reset_n),
    .run(conv_run),
    .div_sel(s_q.ctrl1[2:0]),
    .tick(conv_tick)
  );

  adsq_refsel u_refsel (
    .reference_source_select(s_q.ctrl2[3:0]),
    .bandgap_enable(s_q.ctrl2[ADSQ_C2_BG]),
    .cfg(ref_dec)
  );

  assign start_now = s_q.ctrl0[ADSQ_C0_START];
  // Rising start seen one cycle after the write that sets it
  assign start_rise = start_now && !s_q.start_d1;
  assign cnt_nx = s_q.clk_cnt + 5'h01;
  // Divider starts on the edge the sequence enters sampling, so the
  // n-th tick is consumed exactly n converter periods later
  assign conv_run = (s_d.state == ADSQ_SAMPLE) || (s_d.state == ADSQ_CONVERT);
  // Access phase takes two cycles: pready rises one cycle after penable, with one wait state
  assign wr_en = psel && penable && pwrite && !s_q.pready;
  assign rd_en = psel && !penable;

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.start_d1 = start_now;

    // Register accesses: writes and error response
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      if (wr_en) begin
        case (paddr)
          ADSQ_CTRL0_OFS: s_d.ctrl0 = pwdata[7:0] & ADSQ_C0_WMASK;
          ADSQ_CTRL1_OFS: s_d.ctrl1 = pwdata[7:0] & ADSQ_C1_WMASK;
          ADSQ_CTRL2_OFS: s_d.ctrl2 = pwdata[7:0];
          ADSQ_PINSEL_OFS: s_d.pinsel = pwdata[7:0];
          ADSQ_FLAG_OFS: begin
            if (pwdata[0]) begin
              s_d.irq_flag = 1'b0;
            end
          end
          // Read-only words accept and drop writes
          ADSQ_RESH_OFS, ADSQ_RESL_OFS, ADSQ_SAMPLE_OFS: begin
          end
          default: s_d.pslverr = 1'b1;
        endcase
      end else begin
        case (paddr)
          ADSQ_CTRL0_OFS, ADSQ_CTRL1_OFS, ADSQ_CTRL2_OFS, ADSQ_PINSEL_OFS,
          ADSQ_RESH_OFS, ADSQ_RESL_OFS, ADSQ_FLAG_OFS, ADSQ_SAMPLE_OFS: begin
          end
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end

    // Start sequencing
    case (s_q.state)
      ADSQ_IDLE: begin
        s_d.clk_cnt = 5'h00;
        if (start_rise) begin
          s_d.state = ADSQ_HOLD;
        end
      end
      ADSQ_HOLD: begin
        if (!start_now) begin
          s_d.state = ADSQ_SAMPLE;
          s_d.busy = 1'b1;
          s_d.clk_cnt = 5'h00;
        end
      end
      ADSQ_SAMPLE, ADSQ_CONVERT: begin
        if (conv_tick) begin
          s_d.clk_cnt = cnt_nx;
          if (cnt_nx == ADSQ_SAMPLE_CLKS) begin
            s_d.state = ADSQ_CONVERT;
          end
          // Busy, flag and both result bytes change at one edge
          if (cnt_nx == ADSQ_TOTAL_CLKS) begin
            s_d.state = ADSQ_IDLE;
            s_d.busy = 1'b0;
            s_d.irq_flag = 1'b1;
            s_d.res_h = res_h_nx;
            s_d.res_l = res_l_nx;
          end
        end
      end
      default: s_d.state = ADSQ_IDLE;
    endcase

    // A new rising start edge aborts anything running
    if (start_rise) begin
      s_d.state = ADSQ_HOLD;
      s_d.busy = 1'b0;
    end
    // Power off wins over any conversion in progress
    if (!s_q.ctrl0[ADSQ_C0_PWR]) begin
      s_d.res_h = 8'h00;
      s_d.res_l = 8'h00;
      s_d.busy = 1'b0;
      s_d.state = start_rise ? ADSQ_HOLD : ADSQ_IDLE;
    end

    s_d.conv_rst = (s_d.state == ADSQ_HOLD) || !s_q.ctrl0[ADSQ_C0_PWR];
    s_d.sampling = (s_d.state == ADSQ_SAMPLE);
    s_d.irq = s_d.irq_flag && interrupt_enable;
    s_d.ref_cfg = ref_dec;

    // Pin controls follow the select one cycle after a write
    s_d.pin_en = pin_nx;
    s_d.dir = dir_nx;
    s_d.pull = pull_nx;

    // Read data captured in setup so it is stable during access
    if (rd_en) begin
      s_d.prdata = rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    case (paddr)
      // Bit 6 of control 0 shows live busy, never a stored bit
      ADSQ_CTRL0_OFS: rd_word = {24'h0, s_q.ctrl0[7], s_q.busy, s_q.ctrl0[5:0]};
      ADSQ_CTRL1_OFS: rd_word = {24'h0, s_q.ctrl1};
      ADSQ_CTRL2_OFS: rd_word = {24'h0, s_q.ctrl2};
      ADSQ_PINSEL_OFS: rd_word = {24'h0, s_q.pinsel};
      ADSQ_RESH_OFS: rd_word = {24'h0, s_q.res_h};
      ADSQ_RESL_OFS: rd_word = {24'h0, s_q.res_l};
      ADSQ_FLAG_OFS: rd_word = {31'h0, s_q.irq_flag};
      ADSQ_SAMPLE_OFS: rd_word = {27'h0, s_q.clk_cnt};
      // Unmapped words read as zero, the error goes out on pslverr
      default: rd_word = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Result placement

  always_comb begin
    if (s_q.ctrl0[ADSQ_C0_JUST]) begin
      res_h_nx = {4'h0, conv_data[11:8]};
      res_l_nx = conv_data[7:0];
    end else begin
      // Left form leaves the low nibble of the low byte zero
      res_h_nx = conv_data[11:4];
      res_l_nx = {conv_data[3:0], 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin overrides per pin

  for (genvar i = 0; i < 8; i++) begin : g_pin
    assign pin_nx[i] = s_q.pinsel[i];
    // Analog pins forced to input, pull-up removed
    assign dir_nx[i] = s_q.pinsel[i] ? 1'b1 : port_direction_in[i];
    assign pull_nx[i] = s_q.pinsel[i] ? 1'b0 : pull_high_in[i];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q <= '0;
      // Pins come up analog, so they also come up as inputs
      s_q.pinsel <= ADSQ_PINSEL_RST;
      s_q.pin_en <= ADSQ_PINSEL_RST;
      s_q.dir <= ADSQ_PINSEL_RST;
      s_q.ctrl0 <= ADSQ_CTRL_RST;
      s_q.state <= ADSQ_IDLE;
      s_q.conv_rst <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign analog_pin_enable_bits = s_q.pin_en;
  assign port_direction_out = s_q.dir;
  assign pull_high_out = s_q.pull;
  assign converter_power_enable = s_q.ctrl0[ADSQ_C0_PWR];
  assign converter_reset = s_q.conv_rst;
  assign converter_sampling = s_q.sampling;
  assign channel_select = s_q.ctrl0[2:0];
  assign input_signal_select = s_q.ctrl1[7:5];
  assign reference_cfg = s_q.ref_cfg;
  assign reference_amp_enable = s_q.ctrl2[ADSQ_C2_AMP];
  assign reference_in_pin_enable = s_q.ctrl2[ADSQ_C2_RIN];
  assign reference_out_pin = s_q.ctrl2[ADSQ_C2_ROUT];
  assign conv_irq_flag = s_q.irq_flag;
  assign conv_irq = s_q.irq;
endmodule

// ### rtl/adsq_pkg.sv
// Package: register map, fields, states and timing for the converter sequencer
package adsq_pkg;
  localparam logic [11:0] ADSQ_CTRL0_OFS = 12'h000;
  localparam logic [11:0] ADSQ_CTRL1_OFS = 12'h004;
  localparam logic [11:0] ADSQ_CTRL2_OFS = 12'h008;
  localparam logic [11:0] ADSQ_PINSEL_OFS = 12'h00c;
  localparam logic [11:0] ADSQ_RESH_OFS = 12'h010;
  localparam logic [11:0] ADSQ_RESL_OFS = 12'h014;
  localparam logic [11:0] ADSQ_FLAG_OFS = 12'h018;
  localparam logic [11:0] ADSQ_SAMPLE_OFS = 12'h01c;
  // Control 0 field positions
  localparam int ADSQ_C0_START = 7;
  localparam int ADSQ_C0_BUSY = 6;
  localparam int ADSQ_C0_PWR = 5;
  localparam int ADSQ_C0_JUST = 4;
  // Control 2 field positions
  localparam int ADSQ_C2_AMP = 7;
  localparam int ADSQ_C2_BG = 6;
  localparam int ADSQ_C2_RIN = 5;
  localparam int ADSQ_C2_ROUT = 4;
  localparam logic [7:0] ADSQ_C0_WMASK = 8'hb7;
  localparam logic [7:0] ADSQ_C1_WMASK = 8'he7;
  localparam logic [7:0] ADSQ_PINSEL_RST = 8'hff;
  localparam logic [7:0] ADSQ_CTRL_RST = 8'h00;
  localparam logic [4:0] ADSQ_SAMPLE_CLKS = 5'h04;
  localparam logic [4:0] ADSQ_TOTAL_CLKS = 5'h10;
  localparam logic [6:0] ADSQ_DIV_MAX = 7'h7f;
  // Reference source decode
  typedef enum logic [1:0] {
    ADSQ_REF_SUPPLY = 2'h0,
    ADSQ_REF_EXT = 2'h1,
    ADSQ_REF_BANDGAP = 2'h2
  } adsq_ref_t;
  typedef struct packed {
    adsq_ref_t src;
    logic [1:0] gain_m1;
    logic amp_in_path;
  } adsq_refcfg_t;
  typedef enum logic [3:0] {
    ADSQ_IDLE = 4'b0001,
    ADSQ_HOLD = 4'b0010,
    ADSQ_SAMPLE = 4'b0100,
    ADSQ_CONVERT = 4'b1000
  } adsq_state_t;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } adsq_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } adsq_apb_rsp_t;
endpackage

// ### rtl/adsq_clkdiv.sv
// Power-of-two converter clock tick generator
`timescale 1ns/1ps
module adsq_clkdiv
  import adsq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [2:0] div_sel,
  output logic tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic tick;
  } adsq_div_st_t;
  adsq_div_st_t s_q, s_d;
  logic [6:0] limit;

  always_comb begin
    limit = 7'((8'h01 << div_sel) - 8'h01);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!run) begin
      s_d.cnt = 7'h00;
    end else if (s_q.cnt >= limit) begin
      s_d.cnt = 7'h00;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 7'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// ### rtl/adsq_refsel.sv
// Reference source and amplifier gain decode
`timescale 1ns/1ps
module adsq_refsel
  import adsq_pkg::*;
(
  input wire logic [3:0] reference_source_select,
  input wire logic bandgap_enable,
  output adsq_refcfg_t cfg
);
  always_comb begin
    cfg = '{src: ADSQ_REF_SUPPLY, gain_m1: 2'h0, amp_in_path: 1'b0};
    case (reference_source_select)
      4'h1, 4'h2, 4'h3, 4'h4: begin
        cfg.src = ADSQ_REF_EXT;
        cfg.gain_m1 = 2'(reference_source_select - 4'h1);
        cfg.amp_in_path = 1'b1;
      end
      4'ha, 4'hb, 4'hc: begin
        cfg.src = ADSQ_REF_BANDGAP;
        cfg.gain_m1 = 2'(reference_source_select - 4'h9);
        cfg.amp_in_path = 1'b1;
      end
      default: begin
        cfg.src = ADSQ_REF_SUPPLY;
      end
    endcase
    // Bandgap wins when both sources are requested
    if (bandgap_enable && cfg.src == ADSQ_REF_EXT) begin
      cfg.src = ADSQ_REF_BANDGAP;
    end
  end
endmodule

// ### dv/adsq_asserts.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module adsq_asserts
  import adsq_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] port_direction_in,
  input wire logic [7:0] pull_high_in,
  input wire logic interrupt_enable,
  input wire logic [7:0] analog_pin_enable_bits,
  input wire logic [7:0] port_direction_out,
  input wire logic [7:0] pull_high_out,
  input wire logic converter_power_enable,
  input wire logic converter_reset,
  input wire logic converter_sampling,
  input wire adsq_refcfg_t reference_cfg,
  input wire logic conv_irq_flag,
  input wire logic conv_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////
  pins_reset_a: assert property (
    $rose(reset_n) |-> analog_pin_enable_bits == ADSQ_PINSEL_RST) else $error("pin select reset");
  pdir_override_a: assert property (
    $stable(analog_pin_enable_bits) |->
    port_direction_out == ($past(port_direction_in) | analog_pin_enable_bits))
    else $error("direction override");
  pull_remove_a: assert property (
    $stable(analog_pin_enable_bits) |->
    pull_high_out == ($past(pull_high_in) & ~analog_pin_enable_bits)) else $error("pull-up kept");
  power_off_a: assert property (
    !converter_power_enable && $past(!converter_power_enable) |-> converter_reset)
    else $error("converter not held while off");
  held_idle_a: assert property (
    converter_reset && $past(converter_reset) |-> !converter_sampling)
    else $error("sampling while held");
  irq_follow_a: assert property (
    conv_irq == (conv_irq_flag && $past(interrupt_enable))) else $error("irq mismatch");
  samp_min_a: assert property (
    $rose(converter_sampling) |-> (converter_sampling || converter_reset)[*4])
    else $error("sampling too short");
  samp_max_a: assert property (
    $rose(converter_sampling) |-> ##[1:520] !converter_sampling) else $error("sampling too long");
  ref_amp_path_a: assert property (
    reference_cfg.amp_in_path == (reference_cfg.src != ADSQ_REF_SUPPLY))
    else $error("amplifier path mismatch");
  cover property ($rose(converter_sampling));
  cover property (conv_irq);
  cover property (pready && pslverr);
endmodule
bind adsq_top adsq_asserts u_chk (.clock(clock), .reset_n(reset_n), .pready(pready),
  .pslverr(pslverr), .port_direction_in(port_direction_in), .pull_high_in(pull_high_in),
  .interrupt_enable(interrupt_enable), .analog_pin_enable_bits(analog_pin_enable_bits),
  .port_direction_out(port_direction_out), .pull_high_out(pull_high_out),
  .converter_power_enable(converter_power_enable), .converter_reset(converter_reset),
  .converter_sampling(converter_sampling), .reference_cfg(reference_cfg),
  .conv_irq_flag(conv_irq_flag), .conv_irq(conv_irq));

// ### dv/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb;
  import adsq_pkg::*;
  logic clock = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, interrupt_enable = 0;
  logic [11:0] paddr = 0, conv_data = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [7:0] port_direction_in = 0, pull_high_in = 0;
  logic [7:0] analog_pin_enable_bits, port_direction_out, pull_high_out;
  logic pready, pslverr, converter_power_enable, converter_reset, converter_sampling;
  logic reference_amp_enable, reference_in_pin_enable, reference_out_pin;
  logic conv_irq_flag, conv_irq;
  logic [2:0] channel_select, input_signal_select;
  adsq_refcfg_t reference_cfg;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [15:0] lfsr_q = 16'h3a84;
  int miscompares = 0, check_count = 0, samp_n = 0, conv_n = 0;
  always #2 clock = ~clock;
  adsq_top dut (.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_data, .port_direction_in, .pull_high_in, .interrupt_enable,
    .analog_pin_enable_bits, .port_direction_out, .pull_high_out, .converter_power_enable,
    .converter_reset, .converter_sampling, .channel_select, .input_signal_select,
    .reference_cfg, .reference_amp_enable, .reference_in_pin_enable, .reference_out_pin,
    .conv_irq_flag, .conv_irq);
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Supply gain is left open, so only its source is compared
  function automatic logic [3:0] exp_ref(input logic [3:0] s, input logic bg);
    if (s >= 4'h1 && s <= 4'h4) return {bg ? 2'h2 : 2'h1, s[1:0] - 2'h1};
    if (s >= 4'ha && s <= 4'hc) return {2'h2, s[1:0] - 2'h1};
    return 4'h0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Expectation x: {compare data, expected error, expected data}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [33:0] x);
    int n;
    exp_q.push_back(x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  ////////////////////////////////////////
  always @(posedge clock) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk(pslverr, e[32]);
      if (e[33]) chk(prdata, e[31:0]);
    end
    if (converter_sampling === 1'b1) samp_n++;
    if (converter_sampling === 1'b1 || (conv_n != 0 && conv_irq_flag !== 1'b1)) conv_n++;
  end
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  initial begin
    int n;
    logic [2:0] dv;
    logic j;
    logic [7:0] w0;
    logic [3:0] code;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    apb(0, ADSQ_PINSEL_OFS, 0, {2'b10, 32'hff});
    apb(1, 12'h020, 32'h1, {2'b01, 32'h0});
    for (int i = 0; i < 4; i++) begin
      lfsr_q = lfsr(lfsr_q);
      port_direction_in <= lfsr_q[7:0];
      pull_high_in <= lfsr_q[15:8];
      apb(1, ADSQ_PINSEL_OFS, {24'h0, lfsr_q[11:4]}, 34'h0);
      chk(analog_pin_enable_bits, lfsr_q[11:4]);
      chk(port_direction_out, lfsr_q[7:0] | lfsr_q[11:4]);
      chk(pull_high_out, lfsr_q[15:8] & ~lfsr_q[11:4]);
    end
    for (int c = 0; c < 20; c++) begin
      code = c < 16 ? c[3:0] : c[3:0] - 4'hf;
      apb(1, ADSQ_CTRL2_OFS, {24'h0, 1'b1, c > 15, 2'b10, code}, 34'h0);
      apb(0, ADSQ_CTRL2_OFS, 0, {2'b10, 24'h0, 1'b1, c > 15, 2'b10, code});
      chk({reference_amp_enable, reference_in_pin_enable, reference_out_pin}, 3'b110);
      if (exp_ref(code, c > 15) == 4'h0) chk(reference_cfg.src, 32'h0);
      else chk({reference_cfg.src, reference_cfg.gain_m1}, exp_ref(code, c > 15));
    end
    for (int k = 0; k < 3; k++) begin
      dv = k == 2 ? 3'h7 : k[2:0];
      j = k[0];
      w0 = {3'b001, j, 4'hb};
      lfsr_q = lfsr(lfsr_q);
      conv_data <= lfsr_q[11:0];
      interrupt_enable <= k[1];
      apb(1, ADSQ_CTRL1_OFS, {24'h0, 8'hb8 | dv}, 34'h0);
      apb(0, ADSQ_CTRL1_OFS, 0, {2'b10, 24'h0, 8'ha0 | dv});
      apb(1, ADSQ_CTRL0_OFS, {24'h0, w0}, 34'h0);
      repeat (8) @(posedge clock);
      apb(1, ADSQ_CTRL0_OFS, {24'h0, w0 | 8'h80}, 34'h0);
      apb(0, ADSQ_CTRL0_OFS, 0, {2'b10, 24'h0, w0 & 8'hb7 | 8'h80});
      chk(converter_reset, 1'b1);
      samp_n = 0;
      conv_n = 0;
      apb(1, ADSQ_CTRL0_OFS, {24'h0, w0}, 34'h0);
      apb(0, ADSQ_CTRL0_OFS, 0, {2'b10, 24'h0, w0 & 8'hb7 | 8'h40});
      n = 0;
      do begin
        if (k[1]) @(posedge clock);
        else apb(0, ADSQ_CTRL0_OFS, 0, 34'h0);
        n++;
      end while ((k[1] ? conv_irq_flag !== 1'b1 : prdata[ADSQ_C0_BUSY] !== 1'b0) && n < 3000);
      if (n >= 3000) begin
        miscompares++;
        summarize();
      end
      @(posedge clock);
      chk(samp_n, 4 << dv);
      chk(conv_n, 16 << dv);
      chk(conv_irq, k[1]);
      chk({channel_select, input_signal_select}, 6'h1d);
      apb(0, ADSQ_CTRL0_OFS, 0, {2'b10, 24'h0, w0 & 8'hb7});
      apb(0, ADSQ_RESH_OFS, 0, {2'b10, 24'h0, j ? {4'h0, lfsr_q[11:8]} : lfsr_q[11:4]});
      apb(0, ADSQ_RESL_OFS, 0, {2'b10, 24'h0, j ? lfsr_q[7:0] : {lfsr_q[3:0], 4'h0}});
      apb(0, ADSQ_FLAG_OFS, 0, {2'b10, 32'h1});
      apb(1, ADSQ_FLAG_OFS, 32'h1, 34'h0);
      apb(0, ADSQ_FLAG_OFS, 0, {2'b10, 32'h0});
    end
    // Busy bit is read-only, so this write clears control 0 and powers down
    apb(1, ADSQ_CTRL0_OFS, 32'h40, 34'h0);
    apb(0, ADSQ_CTRL0_OFS, 0, {2'b10, 32'h0});
    apb(0, ADSQ_RESH_OFS, 0, {2'b10, 32'h0});
    apb(0, ADSQ_RESL_OFS, 0, {2'b10, 32'h0});
    chk(converter_reset, 1'b1);
    summarize();
  end
endmodule
